// *** design/vsb_pkg.sv ***
// shared constants of the supervision event block
package vsb_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 100;            // core clock rate
  localparam int MS_PER_MS       = 1;              // one millisecond step
  localparam int CYC_PER_MS      = CLK_MHZ * 1000 * MS_PER_MS;
  localparam int BLOCK_LEAD_MS   = 5;              // blocking lead before expiry
  localparam int MAX_DELAY_MS    = 1800000;        // longest operating delay
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int TS_W    = 48;                     // millisecond time stamp
  localparam int CODE_W  = 4;
  localparam int DLY_W   = 21;                     // delay and remaining time, ms
  localparam int ANG_W   = 16;                     // hundredths of a degree
  localparam int CNT_W   = 16;
  localparam int GRP_W   = 3;                      // eight setting groups
  localparam int SYS_W   = 3;
  localparam int NSTAT   = 6;                      // supervised outputs
  localparam int NEVT    = 12;                     // on/off codes
  localparam int DEPTH   = 12;                     // stored records
  localparam int PTR_W   = 4;
  localparam int REC_W   = TS_W + CODE_W + 8 + SYS_W + 4 * ANG_W + DLY_W + GRP_W;
  localparam int ANG_MAX = 36000;                  // 360.00 deg
  // ---------------------------------------------------------------
  // status bit positions, event code = 2 * bit + (1 for off)
  // ---------------------------------------------------------------
  localparam int ST_START     = 0;
  localparam int ST_TRIP      = 1;
  localparam int ST_BLOCK     = 2;
  localparam int ST_LINE      = 3;
  localparam int ST_BUS_FUSE  = 4;
  localparam int ST_LINE_FUSE = 5;
  // ---------------------------------------------------------------
  // record field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] VOLT_NONE = 2'h0;
  localparam logic [1:0] VOLT_OK   = 2'h1;
  localparam logic [1:0] VOLT_LOW  = 2'h2;
  localparam logic [2:0] SYS_DEAD      = 3'h0;
  localparam logic [2:0] SYS_SEQ_OK    = 3'h1;
  localparam logic [2:0] SYS_SEQ_REV   = 3'h2;
  localparam logic [2:0] SYS_SEQ_UNDEF = 3'h3;
  localparam logic [2:0] SYS_FAULT     = 3'h4;
  // ---------------------------------------------------------------
  // supervision states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    VSB_IDLE    = 2'b00,
    VSB_TIMING  = 2'b01,
    VSB_TRIPPED = 2'b10,
    VSB_BLOCKED = 2'b11
  } vsb_state_t;
endpackage

// *** design/vsb_delay_timer.sv ***
// definite time operating delay counter in milliseconds
`timescale 1ns/1ps
module vsb_delay_timer #(
  parameter int CYC_PER_MS = vsb_pkg::CYC_PER_MS
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     run_i,
  input  wire logic [vsb_pkg::DLY_W-1:0] delay_ms_i,
  output logic                          expired_o,
  output logic [vsb_pkg::DLY_W-1:0]      remain_ms_o
);
  logic [16:0]               cyc;
  logic [vsb_pkg::DLY_W-1:0] elapsed;

  // ---------------------------------------------------------------
  // millisecond prescaler and elapsed count, cleared when idle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc     <= 17'h0;
      elapsed <= '0;
    end else if (!run_i) begin
      cyc     <= 17'h0;
      elapsed <= '0;
    end else if (cyc == 17'(CYC_PER_MS - 1)) begin
      cyc <= 17'h0;
      if (elapsed < delay_ms_i) elapsed <= elapsed + 1'b1;
    end else begin
      cyc <= cyc + 1'b1;
    end
  end

  // outputs depend only on elapsed time, never on magnitude
  assign expired_o   = run_i && (elapsed >= delay_ms_i);
  assign remain_ms_o = (elapsed >= delay_ms_i) ? '0 : delay_ms_i - elapsed;
endmodule

// *** design/vsb_record_store.sv ***
// circular store of the twelve newest operation records
`timescale 1ns/1ps
module vsb_record_store (
  input  wire logic                      core_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      wr_i,
  input  wire logic [vsb_pkg::REC_W-1:0] wdata_i,
  input  wire logic [vsb_pkg::PTR_W-1:0] rd_idx_i,
  output logic      [vsb_pkg::REC_W-1:0] rd_data_o,
  output logic      [vsb_pkg::PTR_W-1:0] count_o
);
  logic [vsb_pkg::REC_W-1:0] mem [vsb_pkg::DEPTH];
  logic [vsb_pkg::PTR_W-1:0] wptr;
  logic [vsb_pkg::PTR_W:0]   back;
  logic [vsb_pkg::PTR_W-1:0] raddr;

  // ---------------------------------------------------------------
  // write pointer wraps so the newest overwrites the oldest
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr    <= '0;
      count_o <= '0;
    end else if (wr_i) begin
      wptr <= (wptr == 4'(vsb_pkg::DEPTH - 1)) ? '0 : wptr + 1'b1;
      if (count_o != 4'(vsb_pkg::DEPTH)) count_o <= count_o + 1'b1;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge core_clk_i) begin
    if (wr_i) mem[wptr] <= wdata_i;
  end

  // index 0 is the newest record
  assign back  = {1'b0, wptr} + 5'(vsb_pkg::DEPTH - 1) - {1'b0, rd_idx_i};
  assign raddr = (back >= 5'(vsb_pkg::DEPTH)) ? 4'(back - 5'(vsb_pkg::DEPTH)) : back[3:0];

  // registered read data
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) rd_data_o <= '0;
    else if (raddr < 4'(vsb_pkg::DEPTH)) rd_data_o <= mem[raddr];
  end
endmodule

// *** design/vsb_event_block.sv ***
// supervision blocking, delay, event and record logic
`timescale 1ns/1ps
module vsb_event_block #(
  parameter int CYC_PER_MS = vsb_pkg::CYC_PER_MS
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          tick_i,        // program cycle start
  input  wire logic                          block_i,       // blocking matrix
  input  wire logic [2:0]                    u_low_i,       // phase under low pick-up
  input  wire logic [2:0]                    u_high_i,      // phase over high detect
  input  wire logic                          line_fail_i,
  input  wire logic [1:0]                    fuse_pin_i,    // bus, line breaker trip pins
  input  wire logic [1:0]                    fuse_chk_i,    // bus, line check enable
  input  wire logic [vsb_pkg::DLY_W-1:0]     delay_ms_i,
  input  wire logic [vsb_pkg::NSTAT-1:0]     on_en_i,       // store on event
  input  wire logic [vsb_pkg::NSTAT-1:0]     off_en_i,      // store off event
  input  wire logic [vsb_pkg::TS_W-1:0]      time_ms_i,
  input  wire logic [7:0]                    volt_stat_i,   // four 2-bit channels
  input  wire logic [vsb_pkg::SYS_W-1:0]     sys_stat_i,
  input  wire logic [4*vsb_pkg::ANG_W-1:0]   angle_i,       // four angle differences
  input  wire logic [vsb_pkg::GRP_W-1:0]     group_i,
  input  wire logic                          cnt_clr_i,
  input  wire logic [vsb_pkg::PTR_W-1:0]     rec_idx_i,
  output logic                               start_o,
  output logic                               trip_o,
  output logic                               blocked_o,
  output logic                               line_fail_o,
  output logic                               bus_fuse_o,
  output logic                               line_fuse_o,
  output logic                               evt_valid_o,
  output logic [vsb_pkg::CODE_W-1:0]         evt_code_o,
  output logic [vsb_pkg::TS_W-1:0]           evt_ts_o,
  output logic [vsb_pkg::CNT_W-1:0]          cnt_start_o,
  output logic [vsb_pkg::CNT_W-1:0]          cnt_bus_o,
  output logic [vsb_pkg::CNT_W-1:0]          cnt_line_o,
  output logic [vsb_pkg::CNT_W-1:0]          cnt_block_o,
  output logic [vsb_pkg::REC_W-1:0]          rec_data_o,
  output logic [vsb_pkg::PTR_W-1:0]          rec_count_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  vsb_pkg::vsb_state_t          state;
  logic                         blk;
  logic                         pickup;
  logic [1:0]                   fs1, fs2, fs3, fuse;
  logic                         expired;
  logic [vsb_pkg::DLY_W-1:0]    remain;
  logic [vsb_pkg::NSTAT-1:0]    stat, stat_q, change;
  logic [vsb_pkg::NEVT-1:0]     pend, served, new_evt;
  logic [vsb_pkg::CODE_W-1:0]   pick;
  logic                         pick_v;
  logic [vsb_pkg::TS_W-1:0]     ts_q;
  logic [vsb_pkg::REC_W-vsb_pkg::CODE_W-vsb_pkg::TS_W-1:0] proc_q;
  logic                         rec_wr;
  logic [vsb_pkg::REC_W-1:0]    rec_wdata;

  // lowest pending event code, used by drain and checks
  function automatic logic [4:0] first_one(input logic [vsb_pkg::NEVT-1:0] v);
    logic [4:0] r;
    r = 5'h0;
    for (int i = vsb_pkg::NEVT - 1; i >= 0; i--) begin
      if (v[i]) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  // one low phase or at least two high phases
  function automatic logic pick_up(input logic [2:0] lo, input logic [2:0] hi);
    return (|lo) || (hi[0] & hi[1]) || (hi[0] & hi[2]) || (hi[1] & hi[2]);
  endfunction

  // ---------------------------------------------------------------
  // fuse pin synchronisers, change taken when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fs1  <= 2'h0;
      fs2  <= 2'h0;
      fs3  <= 2'h0;
      fuse <= 2'h0;
    end else begin
      fs1 <= fuse_pin_i;
      fs2 <= fs1;
      fs3 <= fs2;
      for (int i = 0; i < 2; i++) begin
        if (fs2[i] == fs3[i]) fuse[i] <= fs3[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // blocking sample and pick-up, both taken at the program cycle start
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      blk    <= 1'b0;
      pickup <= 1'b0;
    end else if (tick_i) begin
      blk    <= block_i;
      pickup <= pick_up(u_low_i, u_high_i);
    end
  end

  // ---------------------------------------------------------------
  // supervision state machine, evaluated one clock after the sample
  // ---------------------------------------------------------------
  logic eval;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) eval <= 1'b0;
    else eval <= tick_i;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= vsb_pkg::VSB_IDLE;
    end else if (eval) begin
      case (state)
        vsb_pkg::VSB_IDLE: begin
          if (pickup && !blk) state <= vsb_pkg::VSB_TIMING;
          else if (pickup && blk) state <= vsb_pkg::VSB_BLOCKED;
        end
        vsb_pkg::VSB_TIMING: begin
          if (blk || !pickup) state <= vsb_pkg::VSB_IDLE;
          else if (expired) state <= vsb_pkg::VSB_TRIPPED;
        end
        vsb_pkg::VSB_TRIPPED: begin
          if (!pickup) state <= vsb_pkg::VSB_IDLE;
        end
        vsb_pkg::VSB_BLOCKED: begin
          if (!pickup) state <= vsb_pkg::VSB_IDLE;
        end
        default: state <= vsb_pkg::VSB_IDLE;
      endcase
    end
  end

  // operating delay runs only while timing
  vsb_delay_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .run_i       (state == vsb_pkg::VSB_TIMING),
    .delay_ms_i  (delay_ms_i),
    .expired_o   (expired),
    .remain_ms_o (remain)
  );

  // ---------------------------------------------------------------
  // supervised outputs, refreshed at each evaluation
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_fail_o <= 1'b0;
      bus_fuse_o  <= 1'b0;
      line_fuse_o <= 1'b0;
    end else if (eval) begin
      line_fail_o <= line_fail_i;
      bus_fuse_o  <= fuse[0] & fuse_chk_i[0];
      line_fuse_o <= fuse[1] & fuse_chk_i[1];
    end
  end

  assign start_o   = (state == vsb_pkg::VSB_TIMING) || (state == vsb_pkg::VSB_TRIPPED);
  assign trip_o    = (state == vsb_pkg::VSB_TRIPPED);
  assign blocked_o = (state == vsb_pkg::VSB_BLOCKED);
  assign stat      = {line_fuse_o, bus_fuse_o, line_fail_o, blocked_o, trip_o, start_o};

  // ---------------------------------------------------------------
  // edge detection into pending on/off events
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) stat_q <= '0;
    else stat_q <= stat;
  end

  assign change = stat ^ stat_q;
  always_comb begin
    for (int i = 0; i < vsb_pkg::NSTAT; i++) begin
      new_evt[2*i]   = change[i] & stat[i];
      new_evt[2*i+1] = change[i] & ~stat[i];
    end
  end

  assign {pick_v, pick} = first_one(pend);
  assign served = pick_v ? (12'h1 << pick) : 12'h0;

  // a new edge wins over the serving of the same code
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) pend <= '0;
    else pend <= (pend & ~served) | new_evt;
  end

  // stamp and process data held from the edge that made the events
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ts_q   <= '0;
      proc_q <= '0;
    end else if (|change) begin
      ts_q   <= time_ms_i;
      proc_q <= {volt_stat_i, sys_stat_i, angle_i, remain, group_i};
    end
  end

  // ---------------------------------------------------------------
  // event output, one code per clock, filtered by the on/off choice
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_valid_o <= 1'b0;
      evt_code_o  <= '0;
      evt_ts_o    <= '0;
    end else begin
      evt_valid_o <= pick_v && (pick[0] ? off_en_i[pick[3:1]] : on_en_i[pick[3:1]]);
      evt_code_o  <= pick;
      evt_ts_o    <= ts_q;
    end
  end

  // ---------------------------------------------------------------
  // record capture on on events
  // ---------------------------------------------------------------
  assign rec_wr    = pick_v && !pick[0];
  assign rec_wdata = {ts_q, pick, proc_q};

  vsb_record_store u_store (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (rec_wr),
    .wdata_i    (rec_wdata),
    .rd_idx_i   (rec_idx_i),
    .rd_data_o  (rec_data_o),
    .count_o    (rec_count_o)
  );

  // ---------------------------------------------------------------
  // cumulative counters, clear takes priority
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_start_o <= '0;
      cnt_bus_o   <= '0;
      cnt_line_o  <= '0;
      cnt_block_o <= '0;
    end else if (cnt_clr_i) begin
      cnt_start_o <= '0;
      cnt_bus_o   <= '0;
      cnt_line_o  <= '0;
      cnt_block_o <= '0;
    end else begin
      if (new_evt[2*vsb_pkg::ST_START]) cnt_start_o <= cnt_start_o + 1'b1;
      if (new_evt[2*vsb_pkg::ST_TRIP])  cnt_bus_o   <= cnt_bus_o + 1'b1;
      if (new_evt[2*vsb_pkg::ST_LINE])  cnt_line_o  <= cnt_line_o + 1'b1;
      if (new_evt[2*vsb_pkg::ST_BLOCK]) cnt_block_o <= cnt_block_o + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  blk_sampled_a:  assert property (!tick_i |=> blk == $past(blk))
    else $error("blocking sample moved off the cycle start");
  start_on_a:     assert property (eval && state == vsb_pkg::VSB_IDLE && pickup && !blk
                                   |=> start_o && !blocked_o)
    else $error("unblocked pick-up did not start");
  block_on_a:     assert property (eval && state == vsb_pkg::VSB_IDLE && pickup && blk
                                   |=> blocked_o && !start_o)
    else $error("blocked pick-up did not block");
  block_rel_a:    assert property (eval && state == vsb_pkg::VSB_TIMING && blk
                                   |=> !start_o)
    else $error("start not released by blocking");
  trip_hold_a:    assert property (trip_o |-> $past(start_o))
    else $error("trip without preceding start");
  edge_pend_a:    assert property ($changed(start_o) |=> pend[{3'h0, ~$past(start_o)}])
    else $error("edge produced no pending event");
  evt_mask_a:     assert property (pick_v && !pick[0] && !on_en_i[pick[3:1]]
                                   |=> !evt_valid_o)
    else $error("masked on event stored");
  rec_on_only_a:  assert property (rec_wr |-> !pick[0])
    else $error("record written on off event");
  cnt_clear_a:    assert property (cnt_clr_i |=> cnt_start_o == '0 && cnt_block_o == '0)
    else $error("counters not cleared");
  cnt_step_a:     assert property (!cnt_clr_i && new_evt[0] |=>
                                   cnt_start_o == $past(cnt_start_o) + 1'b1)
    else $error("start counter did not step");

  start_c:   cover property (eval && state == vsb_pkg::VSB_IDLE && pickup && !blk);
  trip_c:    cover property (state == vsb_pkg::VSB_TIMING ##1 trip_o);
  blocked_c: cover property (blocked_o && evt_valid_o);
  rec_c:     cover property (rec_wr && rec_count_o == 4'(vsb_pkg::DEPTH));
endmodule

// *** verification/vsb_far_side.sv ***
// far side model: program cycle ticks and the main event buffer
`timescale 1ns/1ps
module vsb_far_side #(
  parameter int TICK_CYC = 20
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       evt_valid_i,
  input  wire logic [vsb_pkg::CODE_W-1:0] evt_code_i,
  input  wire logic [vsb_pkg::TS_W-1:0]   evt_ts_i,
  output logic                            tick_o
);
  int unsigned cnt;
  logic [51:0] log[$];
  // ---------------------------------------------------------------
  // program cycle start, spaced wide so pending events drain
  // ---------------------------------------------------------------
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      tick_o <= 1'b0;
    end else begin
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      tick_o <= (cnt == TICK_CYC - 2);
    end
  end
  // event buffer keeps code and stamp of every stored event
  always @(posedge core_clk_i) begin
    if (rstn_i && evt_valid_i === 1'b1) begin
      log.push_back({evt_code_i, evt_ts_i});
    end
  end
endmodule

// *** verification/vsb_event_block_test.sv ***
// self-checking bench of the supervision event block
`timescale 1ns/1ps
module vsb_event_block_test;
  logic         core_clk = 1'b0;
  logic         rstn, tick, block, line_fail, cnt_clr, evt_valid;
  logic [2:0]   u_low, u_high, sys, grp;
  logic [1:0]   fuse_pin, fuse_chk;
  logic [20:0]  delay_ms;
  logic [5:0]   on_en, off_en;
  logic [47:0]  tm;
  logic [7:0]   volt;
  logic [63:0]  ang;
  logic [3:0]   rec_idx, rec_count, evt_code;
  wire  [5:0]   st;
  wire  [15:0]  c_st, c_bus, c_ln, c_bk;
  logic [47:0]  evt_ts;
  logic [vsb_pkg::REC_W-1:0] rec_data;
  logic [129:0] eo;
  logic [3:0]   rc;
  int           n_mismatch = 0, checked = 0, n_cyc = 0;

  always #5 core_clk = ~core_clk;

  vsb_event_block #(.CYC_PER_MS(10)) i_dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .tick_i(tick), .block_i(block), .u_low_i(u_low),
    .u_high_i(u_high), .line_fail_i(line_fail), .fuse_pin_i(fuse_pin), .fuse_chk_i(fuse_chk),
    .delay_ms_i(delay_ms), .on_en_i(on_en), .off_en_i(off_en), .time_ms_i(tm),
    .volt_stat_i(volt), .sys_stat_i(sys), .angle_i(ang), .group_i(grp), .cnt_clr_i(cnt_clr),
    .rec_idx_i(rec_idx), .start_o(st[0]), .trip_o(st[1]), .blocked_o(st[2]),
    .line_fail_o(st[3]), .bus_fuse_o(st[4]), .line_fuse_o(st[5]), .evt_valid_o(evt_valid),
    .evt_code_o(evt_code), .evt_ts_o(evt_ts), .cnt_start_o(c_st), .cnt_bus_o(c_bus),
    .cnt_line_o(c_ln), .cnt_block_o(c_bk), .rec_data_o(rec_data), .rec_count_o(rec_count));

  vsb_far_side #(.TICK_CYC(20)) i_far (
    .core_clk_i(core_clk), .rstn_i(rstn), .evt_valid_i(evt_valid), .evt_code_i(evt_code),
    .evt_ts_i(evt_ts), .tick_o(tick));
  // ---------------------------------------------------------------
  // checks and stimulus helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [63:0] got, input logic [63:0] e);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("BAD %0t value %h exp %h", $time, got, e);
    end
  endtask
  task automatic chk_evt(input logic [3:0] c);
    logic [51:0] got;
    got = (i_far.log.size() > 0) ? i_far.log.pop_front() : '1;
    checked++;
    if (got !== {c, tm}) begin
      n_mismatch++;
      $display("BAD %0t event %h exp %h", $time, got, {c, tm});
    end
  endtask
  // record minus remaining time, which depends on timer phase
  task automatic chk_rec(input logic [3:0] idx, input logic [129:0] e);
    rec_idx = idx;
    repeat (2) @(posedge core_clk);
    #1;
    checked++;
    if ({rec_data[vsb_pkg::REC_W-1:24], rec_data[2:0]} !== e) begin
      n_mismatch++;
      $display("BAD %0t record %0d", $time, idx);
    end
  endtask
  function automatic logic [129:0] erec(input logic [3:0] c);
    return {tm, c, volt, sys, ang, grp};
  endfunction
  // fresh random process data for the next status change
  task automatic rnd();
    tm = 48'({$urandom(), $urandom()});
    sys = 3'($urandom_range(4));
    grp = 3'($urandom_range(7));
    for (int i = 0; i < 4; i++) begin
      volt[2*i+:2] = 2'($urandom_range(2));
      ang[16*i+:16] = 16'($urandom_range(vsb_pkg::ANG_MAX));
    end
  endtask
  // wait n program cycles, then let state and events settle
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk iff tick);
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    n_cyc++;
    if (n_cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h00b0));
    {rstn, block, u_low, u_high, line_fail, fuse_pin, cnt_clr, rec_idx} = '0;
    {delay_ms, on_en, off_en, fuse_chk} = {21'h8, 6'h3f, 6'h3f, 2'h3};
    rnd();
    repeat (16) @(posedge core_clk);
    #1 rstn = 1'b1;
    chk_val(64'(st), 64'h0);
    chk_val({c_st, c_bus, c_ln, c_bk}, 64'h0);
    // blocking pulse between ticks is not seen at the tick
    cyc(1);
    u_low = 3'h1 << $urandom_range(2);
    block = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 block = 1'b0;
    cyc(1);
    chk_val(64'(st), 64'h01);
    chk_evt(4'h0);
    chk_rec(4'h0, erec(4'h0));
    chk_val(64'(rec_data[23:3]), 64'(delay_ms));
    cyc(2);
    chk_val(64'(st), 64'h01);
    cyc(3);
    chk_val(64'(st), 64'h03);
    chk_evt(4'h2);
    chk_rec(4'h0, erec(4'h2));
    chk_val(64'(rec_data[23:3]), 64'h0);
    // start off suppressed, trip off stored
    rnd();
    off_en = 6'h3e;
    u_low = 3'h0;
    cyc(1);
    chk_val(64'(st), 64'h0);
    chk_evt(4'h3);
    chk_val(64'(i_far.log.size()), 64'h0);
    off_en = 6'h3f;
    // line and fuse failures drain lowest code first
    rnd();
    line_fail = 1'b1;
    fuse_pin = 2'h3;
    cyc(1);
    chk_val(64'(st), 64'h38);
    for (int k = 6; k < 12; k += 2) chk_evt(4'(k));
    line_fail = 1'b0;
    fuse_pin = 2'h0;
    cyc(1);
    for (int k = 7; k < 12; k += 2) chk_evt(4'(k));
    fuse_chk = 2'h1;
    fuse_pin = 2'h3;
    cyc(1);
    chk_val(64'(st), 64'h10);
    fuse_pin = 2'h0;
    cyc(1);
    fuse_chk = 2'h3;
    i_far.log.delete();
    // one high phase alone, then two high while blocked
    rnd();
    u_high = 3'h2;
    cyc(1);
    chk_val(64'(st), 64'h0);
    block = 1'b1;
    u_high = 3'h5;
    cyc(1);
    chk_val(64'(st), 64'h04);
    chk_evt(4'h4);
    chk_rec(4'h0, erec(4'h4));
    u_high = 3'h0;
    block = 1'b0;
    cyc(1);
    chk_evt(4'h5);
    chk_val({c_st, c_bus, c_ln, c_bk}, {16'h1, 16'h1, 16'h1, 16'h1});
    // blocking while timing, 6 ms before expiry
    u_low = 3'h4;
    cyc(1);
    block = 1'b1;
    cyc(1);
    chk_val(64'(st[1:0]), 64'h0);
    block = 1'b0;
    u_low = 3'h0;
    cyc(2);
    rc = rec_count;
    cnt_clr = 1'b1;
    @(posedge core_clk);
    #1 cnt_clr = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk_val({c_st, c_bus, c_ln, c_bk}, 64'h0);
    chk_val(64'(rec_count), 64'(rc));
    // fill the circular store past its depth
    for (int k = 0; k < 13; k++) begin
      i_far.log.delete();
      rnd();
      u_low = 3'h1 << $urandom_range(2);
      cyc(1);
      chk_evt(4'h0);
      if (k == 1) eo = erec(4'h0);
      u_low = 3'h0;
      cyc(1);
    end
    chk_val(64'(rec_count), 64'hc);
    chk_rec(4'h0, erec(4'h0));
    chk_rec(4'hb, eo);
    tally_and_finish();
  end
endmodule
